//--- hdl/eepp_port.sv
// programming port sequencer with its word fifo
// Notes on behaviour
// - store full 192-bit serial configuration image
// - sixteen bits then complement, clocked serially
// - acknowledge bit presented after each write
// - first word triggers automatic bulk write
// - verify shifts stored bits out serially
// - verify only once, only after programming
`timescale 1ns/1ps
`default_nettype none

// *****************************************
// word fifo
// *****************************************
module eepp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk_i, // core clock
   input wire logic sys_rst_i, // synchronous reset
   input wire logic [WIDTH-1:0] in_data_i, // word to store
   input wire logic in_valid_i, // word offered
   output logic in_ready_o, // room for a word
   output logic [WIDTH-1:0] out_data_o, // oldest word
   output logic out_valid_o, // a word is held
   input wire logic out_ready_i // drain takes the word
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem; // storage
      logic [AW-1:0] wp; // write pointer
      logic [AW-1:0] rp; // read pointer
      logic [AW:0] cnt; // occupancy
   } eepp_fifo_s;
   eepp_fifo_s r, next_r;
   logic do_in, do_out;

   // handshakes come straight from occupancy
   assign in_ready_o = (r.cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (r.cnt != '0);
   assign out_data_o = r.mem[r.rp];
   assign do_in = in_valid_i & in_ready_o;
   assign do_out = out_valid_o & out_ready_i;

   // pointer and storage update
   always_comb begin
      next_r = r;
      if (do_in) begin
         next_r.mem[r.wp] = in_data_i;
         next_r.wp = (r.wp == AW'(DEPTH-1)) ? '0 : r.wp + 1'b1;
      end
      if (do_out) begin
         next_r.rp = (r.rp == AW'(DEPTH-1)) ? '0 : r.rp + 1'b1;
      end
      next_r.cnt = r.cnt + (AW+1)'(do_in) - (AW+1)'(do_out);
   end

   // state register
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule

// *****************************************
// port sequencer
// *****************************************
module eepp_port #(
   parameter int HOLD_CYCLES = eepp_pkg::HOLD_CYC, // button three hold
   parameter int SETUP_CYCLES = eepp_pkg::SETUP_CYC, // data pin rise window
   parameter int PROG_CYCLES = eepp_pkg::PROG_CYC // array write time
) (
   input wire logic ref_clk_i, // core clock, 250 mhz
   input wire logic sys_rst_i, // synchronous reset, high
   input wire logic button_line_zero_i, // must stay low while programming
   input wire logic button_line_one_i, // first key lsb level
   input wire logic button_line_two_i, // alternate serial clock
   input wire logic button_line_three_i, // entry hold and serial clock
   input wire logic data_pin_i, // transmit-data pin level
   output logic data_pin_o, // transmit-data pin drive
   output logic data_pin_oe_o, // high while driving the pin
   output logic prog_active_o // programming mode is active
);
   import eepp_pkg::*;

   eepp_core_s r, next_r; // whole state and its next value
   logic clk_now; // synchronised serial clock
   logic clk_rise; // one cycle on its rising edge
   logic abort; // button zero seen high
   logic [IMAGE_BITS-1:0] mem_flat; // array as a bit vector
   logic fifo_in_ready; // fifo has room
   logic [WORD_BITS-1:0] fifo_out_data; // word to commit
   logic fifo_out_valid; // word waiting to commit
   logic pop; // word committed this cycle

   // either button may clock; the second sync stage is the first read
   assign clk_now = r.sync[3] | r.sync[2];
   assign clk_rise = clk_now & ~r.clk_q;
   assign abort = r.sync[0];
   assign mem_flat = r.mem;
   // array write engine drains one word per write time
   assign pop = fifo_out_valid & ~r.busy;

   assign data_pin_o = r.dout;
   assign data_pin_oe_o = r.doe;
   assign prog_active_o = (r.st == ST_RX) || (r.st == ST_WRITE) || (r.st == ST_ACK) || (r.st == ST_VERIFY);

   // words wait here while the array is busy; full fifo stalls the sequencer
   eepp_fifo #(
      .WIDTH(WORD_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .in_data_i(r.shreg[15:0]),
      .in_valid_i(r.push_pend),
      .in_ready_o(fifo_in_ready),
      .out_data_o(fifo_out_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(~r.busy)
   );

   // next state of the whole port
   always_comb begin
      next_r = r;
      next_r.meta = {data_pin_i, button_line_three_i, button_line_two_i, button_line_one_i, button_line_zero_i};
      next_r.sync = r.meta;
      next_r.clk_q = clk_now;
      if (pop) begin
         if (r.rptr == 4'h0) begin
            next_r.mem = '0;
         end
         next_r.mem[r.rptr] = fifo_out_data;
         next_r.rptr = r.rptr + 4'h1;
         next_r.busy = 1'b1;
         next_r.wtmr = TIMER_ZERO;
      end else if (r.busy) begin
         // write finishes after the full cycle time
         if (r.wtmr == 24'(PROG_CYCLES - 1)) begin
            next_r.busy = 1'b0;
         end else begin
            next_r.wtmr = r.wtmr + 24'h1;
         end
      end
      // fifo took the word
      if (r.push_pend && fifo_in_ready) begin
         next_r.push_pend = 1'b0;
      end
      unique case (r.st)
         ST_IDLE: begin
            // wait for button three to go high
            next_r.tmr = TIMER_ZERO;
            if (r.sync[3]) begin
               next_r.st = ST_HOLD;
            end
         end
         ST_HOLD: begin
            // button three must stay high for the hold time
            if (!r.sync[3]) begin
               next_r.st = ST_IDLE;
            end else if (r.tmr == 24'(HOLD_CYCLES - 1)) begin
               next_r.st = ST_ARMED;
               next_r.tmr = TIMER_ZERO;
            end else begin
               next_r.tmr = r.tmr + 24'h1;
            end
         end
         ST_ARMED: begin
            // data pin must rise inside the setup window
            if (r.sync[4] && !abort) begin
               next_r.st = ST_RX;
               next_r.bitcnt = 5'h0;
               next_r.wptr = 4'h0;
               next_r.rptr = 4'h0;
               next_r.verify_used = 1'b0;
               next_r.key_lsb = r.sync[1];
            end else if (r.tmr == 24'(SETUP_CYCLES)) begin
               next_r.st = ST_IDLE;
            end else begin
               next_r.tmr = r.tmr + 24'h1;
            end
         end
         ST_RX: begin
            if (abort) begin
               next_r.st = ST_IDLE;
            end else if (clk_rise) begin
               next_r.shreg = {r.sync[4], r.shreg[31:1]};
               next_r.bitcnt = r.bitcnt + 5'h1;
               if (r.bitcnt == FRAME_LAST) begin
                  next_r.ack_ok = (next_r.shreg[15:0] == ~next_r.shreg[31:16]);
                  // first word lsb must match button one level
                  if (r.wptr == 4'h0 && next_r.shreg[0] != r.key_lsb) begin
                     next_r.ack_ok = 1'b0;
                  end
                  if (next_r.ack_ok) begin
                     next_r.push_pend = 1'b1;
                     next_r.wptr = r.wptr + 4'h1;
                  end
                  next_r.st = ST_WRITE;
               end
            end
         end
         ST_WRITE: begin
            // wait until every accepted word is in the array
            if (abort) begin
               next_r.st = ST_IDLE;
            end else if (!r.push_pend && !fifo_out_valid && !r.busy && !pop) begin
               next_r.st = ST_ACK;
               next_r.dout = r.ack_ok;
               next_r.doe = 1'b1;
            end
         end
         ST_ACK: begin
            // ack is read on the next clock rise
            if (abort) begin
               next_r.st = ST_IDLE;
               next_r.doe = 1'b0;
            end else if (clk_rise) begin
               if (r.wptr == WORDS_FULL && !r.verify_used) begin
                  next_r.st = ST_VERIFY;
                  next_r.vidx = 8'h00;
                  next_r.dout = mem_flat[0];
               end else begin
                  next_r.st = ST_RX;
                  next_r.bitcnt = 5'h0;
                  next_r.doe = 1'b0;
               end
            end
         end
         ST_VERIFY: begin
            if (abort) begin
               next_r.st = ST_IDLE;
               next_r.doe = 1'b0;
               next_r.verify_used = 1'b1;
            end else if (clk_rise) begin
               if (r.vidx == VERIFY_LAST) begin
                  next_r.st = ST_IDLE;
                  next_r.doe = 1'b0;
                  next_r.verify_used = 1'b1;
               end else begin
                  next_r.vidx = r.vidx + 8'h01;
                  next_r.dout = mem_flat[r.vidx + 8'h01];
               end
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // *****************************************
   // assertions
   // *****************************************
   property p_full_image;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      (r.st == ST_ACK && clk_rise && !abort && r.wptr == WORDS_FULL && !r.verify_used) |=> (r.st == ST_VERIFY);
   endproperty
   a_full_image: assert property (p_full_image) else $error("full image did not enter verify");

   property p_complement;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      $rose(r.push_pend) |-> (r.shreg[15:0] == ~r.shreg[31:16]);
   endproperty
   a_complement: assert property (p_complement) else $error("word accepted with bad complement");

   property p_ack_value;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      $rose(r.st == ST_ACK) |-> (r.doe && r.dout == r.ack_ok && !r.busy);
   endproperty
   a_ack_value: assert property (p_ack_value) else $error("acknowledge bit wrong");

   property p_bulk_write;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      (pop && r.rptr == 4'h0) |=> (r.busy && r.mem[11:1] == '0) ##1 r.busy;
   endproperty
   a_bulk_write: assert property (p_bulk_write) else $error("bulk write not started");

   property p_verify_shift;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      (r.st == ST_VERIFY && clk_rise && !abort && r.vidx != VERIFY_LAST) |=>
         (r.vidx == $past(r.vidx) + 8'h01 && r.dout == mem_flat[r.vidx]);
   endproperty
   a_verify_shift: assert property (p_verify_shift) else $error("verify bit not advanced");

   property p_verify_once;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      $rose(r.st == ST_VERIFY) |-> ($past(r.st) == ST_ACK && r.wptr == WORDS_FULL && !r.verify_used);
   endproperty
   a_verify_once: assert property (p_verify_once) else $error("verify without fresh programming");

   property p_pin_turn;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      r.doe |-> (r.st == ST_ACK || r.st == ST_VERIFY);
   endproperty
   a_pin_turn: assert property (p_pin_turn) else $error("data pin driven outside ack or verify");
endmodule

`default_nettype wire

//--- hdl/eepp_pkg.sv
// shared constants and types for the encoder eeprom programming port
`default_nettype none
package eepp_pkg;
   // *****************************************
   // clock and timing
   // *****************************************
   localparam int CLK_MHZ = 250; // core clock rate in mhz
   localparam int MODE_ENTRY_HOLD_TIME_US = 9000; // least button three hold, 9.0 ms
   localparam int MODE_ENTRY_SETUP_TIME_US = 4000; // longest wait for data pin rise, 4.0 ms
   localparam int PROG_CYCLE_TIME_US = 50000; // nonvolatile write time, 50 ms
   localparam int HOLD_CYC = MODE_ENTRY_HOLD_TIME_US * CLK_MHZ; // least time, exact
   localparam int SETUP_CYC = MODE_ENTRY_SETUP_TIME_US * CLK_MHZ; // longest time, exact
   localparam int PROG_CYC = PROG_CYCLE_TIME_US * CLK_MHZ; // write time in cycles
   // *****************************************
   // image layout
   // *****************************************
   localparam int WORD_BITS = 16; // data bits per word
   localparam int FRAME_BITS = 32; // word plus its complement
   localparam int IMAGE_BITS = 192; // total configuration bits
   localparam int IMAGE_WORDS = 12; // words in the image
   localparam int FIFO_DEPTH = 8; // words buffered ahead of the array
   localparam logic [4:0] FRAME_LAST = 5'h1f; // index of last frame bit
   localparam logic [3:0] WORDS_FULL = 4'hc; // word count of a full image
   localparam logic [7:0] VERIFY_LAST = 8'hbf; // index of last verify bit
   localparam logic [23:0] TIMER_ZERO = 24'h000000; // timer reset value
   // *****************************************
   // state types
   // *****************************************
   typedef enum logic [2:0] {ST_IDLE, ST_HOLD, ST_ARMED, ST_RX, ST_WRITE, ST_ACK, ST_VERIFY} eepp_state_e;
   typedef struct packed {
      eepp_state_e st; // sequencer state
      logic [4:0] meta; // first synchroniser stage
      logic [4:0] sync; // second synchroniser stage
      logic clk_q; // previous synchronised clock level
      logic [23:0] tmr; // mode entry timer
      logic [4:0] bitcnt; // bits received in frame
      logic [31:0] shreg; // frame shift register
      logic key_lsb; // level of button line one at entry
      logic ack_ok; // acknowledge value
      logic push_pend; // word waiting for the fifo
      logic [3:0] wptr; // words accepted this session
      logic [3:0] rptr; // words committed to the array
      logic busy; // array write in progress
      logic [23:0] wtmr; // array write timer
      logic [IMAGE_WORDS-1:0][WORD_BITS-1:0] mem; // nonvolatile array
      logic [7:0] vidx; // verify bit index
      logic verify_used; // read-back already spent
      logic dout; // data pin drive value
      logic doe; // data pin drive enable
   } eepp_core_s;
endpackage
`default_nettype wire

//--- bench/eepp_prog_model.sv
// programmer model: button lines and data pin of the port
`timescale 1ns/1ps
`default_nettype none
module eepp_prog_model (
   input wire logic ref_clk_i, // core clock
   input wire logic pin_i, // resolved data pin level
   input wire logic oe_i, // device drives the pin
   output logic button_line_zero_o, // low while programming
   output logic button_line_one_o, // first key lsb level
   output logic button_line_two_o, // alternate serial clock
   output logic button_line_three_o, // entry hold and clock
   output logic pval_o, // our pin drive value
   output logic pen_o // high while we drive the pin
);
   // idle levels: clocks low, pin driven low
   initial begin
      {button_line_zero_o, button_line_one_o, button_line_two_o, button_line_three_o, pval_o} = 5'h00;
      pen_o = 1'b1;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   // eight core cycles per phase, sample before rise
   task automatic pulse(input logic use2, output logic [1:0] seen);
      cyc(7);
      @(negedge ref_clk_i);
      seen = {oe_i, pin_i};
      @(posedge ref_clk_i);
      if (use2) begin
         button_line_two_o <= 1'b1;
      end else begin
         button_line_three_o <= 1'b1;
      end
      cyc(8);
      button_line_two_o <= 1'b0;
      button_line_three_o <= 1'b0;
   endtask
   // timed hold, then pin rise after gap
   task automatic enter(input int hold, input int gap, input logic key0);
      @(posedge ref_clk_i);
      button_line_zero_o <= 1'b0;
      button_line_one_o <= key0;
      pen_o <= 1'b1;
      pval_o <= 1'b0;
      cyc(20);
      button_line_three_o <= 1'b1;
      cyc(hold + gap);
      pval_o <= 1'b1;
      cyc(4);
      button_line_three_o <= 1'b0;
      cyc(20);
   endtask
   // frame lsb first, release pin, wait out the write, read ack
   task automatic send_word(input logic [31:0] frame, input logic use2, output int waited,
         output logic [1:0] ack, output logic oe_seen);
      logic [1:0] s;
      oe_seen = 1'b0;
      @(posedge ref_clk_i);
      pen_o <= 1'b1;
      for (int i = 0; i < 32; i++) begin
         pval_o <= frame[i];
         pulse(use2, s);
         oe_seen |= s[1];
      end
      pen_o <= 1'b0;
      waited = 0;
      while (oe_i !== 1'b1 && waited < 400) begin
         @(negedge ref_clk_i);
         waited++;
      end
      pulse(use2, ack);
   endtask
   // one bit per rise, pin left to the device
   task automatic read_image(output logic [191:0] img, output logic oe_all);
      logic [1:0] s;
      oe_all = 1'b1;
      for (int i = 0; i < 192; i++) begin
         pulse(1'b0, s);
         img[i] = s[0];
         oe_all &= s[1];
      end
   endtask
   // line zero high aborts the session
   task automatic abort();
      @(posedge ref_clk_i);
      button_line_zero_o <= 1'b1;
      cyc(20);
      button_line_zero_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- bench/tb_eepp_port.sv
// self-checking bench of the programming port and its word fifo
`timescale 1ns/1ps
`default_nettype none
module tb_eepp_port;
   import eepp_pkg::*;
   localparam int HOLD = 200; // shortened entry hold
   localparam int SETUP = 400; // shortened setup window
   localparam int PROG = 100; // shortened write time
   localparam logic [15:0] W0 = 16'h3c5a; // first image word, lsb 0
   logic ref_clk = 1'b0; // core clock
   logic sys_rst = 1'b1; // synchronous reset
   logic b0, b1, b2, b3, pval, pen, dout, doe, active; // pin levels
   logic last = 1'b0; // previous pin level
   wire pin; // resolved data pin
   int num_errors = 0;
   int checks = 0;
   // released pin wanders so a stale level cannot pass
   assign pin = doe ? dout : (pen ? pval : ~last);
   always @(posedge ref_clk) last <= pin;
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   eepp_port #(.HOLD_CYCLES(HOLD), .SETUP_CYCLES(SETUP), .PROG_CYCLES(PROG)) i_eepp_port (.ref_clk_i(ref_clk),
      .sys_rst_i(sys_rst), .button_line_zero_i(b0), .button_line_one_i(b1), .button_line_two_i(b2),
      .button_line_three_i(b3), .data_pin_i(pin), .data_pin_o(dout), .data_pin_oe_o(doe), .prog_active_o(active));
   eepp_prog_model i_eepp_prog_model (.ref_clk_i(ref_clk), .pin_i(pin), .oe_i(doe), .button_line_zero_o(b0),
      .button_line_one_o(b1), .button_line_two_o(b2), .button_line_three_o(b3), .pval_o(pval), .pen_o(pen));
   function automatic logic [15:0] word(input int k);
      return W0 + 16'h0f1d * k[15:0];
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (num_errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_entry();
      i_eepp_prog_model.enter(HOLD / 2, 0, 1'b0);
      @(negedge ref_clk);
      check(32'(active), 32'h0);
      i_eepp_prog_model.enter(HOLD + 10, SETUP + 40, 1'b0);
      @(negedge ref_clk);
      check(32'(active), 32'h0);
   endtask
   task automatic t_partial();
      int n;
      logic [1:0] ack;
      logic oe;
      i_eepp_prog_model.enter(HOLD + 10, 4, ~W0[0]);
      @(negedge ref_clk);
      check(32'(active), 32'h1);
      i_eepp_prog_model.send_word({~W0, W0}, 1'b0, n, ack, oe);
      check(32'(ack), 32'h2);
      i_eepp_prog_model.abort();
      i_eepp_prog_model.enter(HOLD + 10, 4, W0[0]);
      i_eepp_prog_model.send_word({~W0, W0}, 1'b1, n, ack, oe);
      check(32'({oe, ack}), 32'h3);
      i_eepp_prog_model.send_word({W0, W0}, 1'b0, n, ack, oe);
      check(32'({oe, ack}), 32'h2);
      i_eepp_prog_model.abort();
      @(negedge ref_clk);
      check(32'({active, doe}), 32'h0);
   endtask
   task automatic t_full();
      int n;
      logic [1:0] ack;
      logic oe;
      logic [191:0] img;
      i_eepp_prog_model.enter(HOLD + 10, SETUP - 40, W0[0]);
      for (int k = 0; k < IMAGE_WORDS; k++) begin
         i_eepp_prog_model.send_word({~word(k), word(k)}, k[0], n, ack, oe);
         check(32'({oe, ack}), 32'h3);
         check(32'(n + 8 >= PROG && n < PROG + 40), 32'h1);
      end
      i_eepp_prog_model.read_image(img, oe);
      for (int k = 0; k < IMAGE_WORDS; k++) begin
         check(32'(img[k*WORD_BITS +: WORD_BITS]), 32'(word(k)));
      end
      @(negedge ref_clk);
      check(32'({oe, active, doe}), 32'h4);
   endtask
   // one good word through the fifo; an early ack clock must not start a read-back
   task automatic t_refuse();
      int n;
      logic [1:0] ack;
      logic oe;
      i_eepp_prog_model.enter(HOLD + 10, 4, W0[0]);
      i_eepp_prog_model.send_word({~W0, W0}, 1'b1, n, ack, oe);
      check(32'({oe, ack}), 32'h3);
      check(32'(n + 8 >= PROG && n < PROG + 40), 32'h1);
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      check(32'({active, doe}), 32'h2);
      i_eepp_prog_model.abort();
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_entry();
      t_partial();
      t_full();
      t_refuse();
      complete_run();
   end
endmodule
`default_nettype wire
